// ===== gsp_pkg.sv
package gsp_pkg;
    localparam logic [5:0] ADDR_HI = 6'h3A;
    localparam logic [7:0] GC_ADDR = 8'h00;
    localparam logic [7:0] GC_RESET = 8'h06;
    localparam logic [4:0] HS_CODE_HI = 5'h01;
    localparam int SYS_CLK_MHZ = 200;
    localparam int LINK_KHZ = 400;
    localparam int HALF_CYC = (SYS_CLK_MHZ * 1000) / (LINK_KHZ * 2);
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [1:0] SYNC_RST = 2'h3;
    typedef enum logic [3:0] {
        SL_IDLE = 4'b0001,
        SL_RECV = 4'b0010,
        SL_ACK = 4'b0100,
        SL_IGNORE = 4'b1000
    } gsp_slv_st_t;
    typedef enum logic [5:0] {
        MS_IDLE = 6'b000001,
        MS_START = 6'b000010,
        MS_BIT = 6'b000100,
        MS_ACK = 6'b001000,
        MS_STOP = 6'b010000,
        MS_DONE = 6'b100000
    } gsp_mst_st_t;
endpackage : gsp_pkg

// ===== gsp_if.sv
`timescale 1ns/10ps
interface gsp_if;
    logic clk_out;
    logic clk_oe;
    logic data_out;
    logic data_oe;
    logic dev_data_out;
    logic dev_data_oe;
    wire clk_line;
    wire data_line;
    // open-drain resolve: any enabled driver pulls low
    assign clk_line = ~(clk_oe & ~clk_out);
    assign data_line = ~((data_oe & ~data_out) | (dev_data_oe & ~dev_data_out));
    modport dev (input clk_line, input data_line, output dev_data_out, output dev_data_oe);
    modport mst (input clk_line, input data_line, output clk_out, output clk_oe,
        output data_out, output data_oe);
endinterface : gsp_if

// ===== gsp_slave.sv
`timescale 1ns/10ps
// How it works
// - lines only pulled low, else released
// - master starts: data falls, clock high
// - sample on rising clock, bit8 direction
// - ack matching address on ninth clock
// - each byte eight bits plus ack
// - data change under high clock: start/stop
// - master stops: data rises, clock high
// - slave only, clock never driven
// - address 111010 plus select pin
// - general call 00h then 06h reset
// - ack general call, reset only on 06h
// - master code 00001xxx enters hs mode
// - master code unacked, hs ends at stop
// - bank pin picks bank one or zero
module gsp_slave (
    input wire logic clk,
    input wire logic nrst,
    gsp_if.dev bus,
    input wire logic address_select_pin,
    input wire logic bank_select_pin,
    output logic bank_sel_q,
    output logic hs_mode_q,
    output logic gc_reset_q,
    output logic wr_valid_q,
    output logic [7:0] wr_byte_q,
    output logic rd_dir_q
);
    import gsp_pkg::*;
    logic [1:0] scl_s_q, sda_s_q, a0_s_q, bk_s_q;
    logic scl_q, sda_q;
    gsp_slv_st_t st_q;
    logic [3:0] bit_q;
    logic [7:0] sh_q;
    logic first_q, gc_q, ack_now_q, sda_oe_q;
    logic scl_rise, scl_fall, start_det, stop_det;
    logic [7:0] rx;
    logic addr_end;
    logic data_end;
    logic ack_end;

    // two-stage synchronisers for the pins
    always_ff @(posedge clk) begin
        if (!nrst) begin
            scl_s_q <= SYNC_RST;
            sda_s_q <= SYNC_RST;
            a0_s_q <= 2'h0;
            bk_s_q <= 2'h0;
        end else begin
            scl_s_q <= {scl_s_q[0], bus.clk_line};
            sda_s_q <= {sda_s_q[0], bus.data_line};
            a0_s_q <= {a0_s_q[0], address_select_pin};
            bk_s_q <= {bk_s_q[0], bank_select_pin};
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_s_q[1];
            sda_q <= sda_s_q[1];
        end
    end

    // edges from the synchronised pins, about three clocks behind the bus
    assign scl_rise = scl_s_q[1] & ~scl_q;
    assign scl_fall = ~scl_s_q[1] & scl_q;
    assign start_det = scl_s_q[1] & scl_q & sda_q & ~sda_s_q[1];
    assign stop_det = scl_s_q[1] & scl_q & ~sda_q & sda_s_q[1];
    assign rx = {sh_q[6:0], sda_s_q[1]};

    // byte boundary: falling clock once eight bits are
    function automatic logic byte_done(
            input gsp_slv_st_t st,
            input logic fall,
            input logic [3:0] cnt
    );
        return st == SL_RECV && fall && cnt == BIT_ACK;
    endfunction : byte_done
    assign addr_end = byte_done(st_q, scl_fall, bit_q) && first_q;
    assign data_end = byte_done(st_q, scl_fall, bit_q) && !first_q;
    assign ack_end = st_q == SL_ACK && scl_fall;

    // pin only followed; nothing is read from the banks here
    always_ff @(posedge clk) begin
        if (!nrst) begin
            bank_sel_q <= 1'b0;
        end else begin
            bank_sel_q <= bk_s_q[1];
        end
    end

    // byte engine; only the data line is ever driven
    always_ff @(posedge clk) begin
        if (!nrst || gc_reset_q) begin
            st_q <= SL_IDLE;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            first_q <= 1'b0;
            gc_q <= 1'b0;
            ack_now_q <= 1'b0;
        end else if (start_det) begin
            st_q <= SL_RECV;
            bit_q <= 4'h0;
            first_q <= 1'b1;
            gc_q <= 1'b0;
            ack_now_q <= 1'b0;
        end else if (stop_det) begin
            st_q <= SL_IDLE;
            ack_now_q <= 1'b0;
        end else begin
            unique case (st_q)
                SL_IDLE, SL_IGNORE: begin
                    ack_now_q <= 1'b0;
                end
                SL_RECV: begin
                    if (scl_rise) begin
                        sh_q <= rx;
                        bit_q <= bit_q + 4'h1;
                    end else if (scl_fall && bit_q == BIT_ACK) begin
                        st_q <= SL_ACK;
                        if (first_q) begin
                            if (sh_q[7:1] == {ADDR_HI, a0_s_q[1]}) begin
                                ack_now_q <= 1'b1;
                            end else if (sh_q == GC_ADDR) begin
                                ack_now_q <= 1'b1;
                                gc_q <= 1'b1;
                            end else begin
                                ack_now_q <= 1'b0;
                            end
                        end else begin
                            ack_now_q <= !gc_q || sh_q == GC_RESET;
                        end
                    end
                end
                SL_ACK: begin
                    if (scl_fall) begin
                        first_q <= 1'b0;
                        bit_q <= 4'h0;
                        ack_now_q <= 1'b0;
                        st_q <= ack_now_q ? SL_RECV : SL_IGNORE;
                    end
                end
                default: st_q <= SL_IDLE;
            endcase
        end
    end

    // ack by pulling low on the ninth clock
    always_ff @(posedge clk) begin
        if (!nrst) begin
            sda_oe_q <= 1'b0;
        end else begin
            sda_oe_q <= st_q == SL_ACK && ack_now_q && !start_det && !stop_det;
        end
    end
    assign bus.dev_data_out = 1'b0;
    assign bus.dev_data_oe = sda_oe_q;

    // master code seen; sticky across repeated starts
    always_ff @(posedge clk) begin
        if (!nrst || gc_reset_q || stop_det) begin
            hs_mode_q <= 1'b0;
        end else if (addr_end
                && sh_q[7:3] == HS_CODE_HI) begin
            hs_mode_q <= 1'b1;
        end
    end

    // reset pulse waits for the ack clock to end, else the ack is cut short
    always_ff @(posedge clk) begin
        if (!nrst) begin
            gc_reset_q <= 1'b0;
        end else begin
            gc_reset_q <= ack_end && !first_q && gc_q && ack_now_q
                && !gc_reset_q;
        end
    end

    // general-call bytes are commands, never handed over as data
    always_ff @(posedge clk) begin
        if (!nrst) begin
            wr_valid_q <= 1'b0;
        end else begin
            wr_valid_q <= data_end && !gc_q;
        end
    end

    // held until the next byte; no buffering beyond one byte
    always_ff @(posedge clk) begin
        if (!nrst) begin
            wr_byte_q <= 8'h00;
        end else if (data_end) begin
            wr_byte_q <= sh_q;
        end
    end

    // direction kept for the host; this link only writes
    always_ff @(posedge clk) begin
        if (!nrst || gc_reset_q) begin
            rd_dir_q <= 1'b0;
        end else if (addr_end) begin
            rd_dir_q <= sh_q[0];
        end
    end
endmodule : gsp_slave

// ===== gsp_master.sv
`timescale 1ns/10ps
module gsp_master (
    input wire logic clk,
    input wire logic nrst,
    gsp_if.mst bus,
    input wire logic req,
    input wire logic [6:0] req_addr,
    input wire logic [7:0] req_data,
    input wire logic req_two,
    output logic busy_q,
    output logic addr_ack_q,
    output logic data_ack_q,
    output logic done_q
);
    import gsp_pkg::*;
    gsp_mst_st_t st_q;
    logic [15:0] div_q;
    logic tick;
    logic [1:0] ph_q;
    logic [3:0] bit_q;
    logic [7:0] sh_q, nxt_q;
    logic byte1_q, two_q, scl_oe_q, sda_oe_q;
    logic [1:0] sda_s_q;

    assign tick = div_q == 16'(HALF_CYC / 2 - 1);
    always_ff @(posedge clk) begin
        if (!nrst || tick || st_q == MS_IDLE) begin
            div_q <= 16'h0000;
        end else begin
            div_q <= div_q + 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            sda_s_q <= SYNC_RST;
        end else begin
            sda_s_q <= {sda_s_q[0], bus.data_line};
        end
    end

    // four quarter phases per bit; clock released in 2 and 3
    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_q <= MS_IDLE;
            ph_q <= 2'h0;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            nxt_q <= 8'h00;
            byte1_q <= 1'b0;
            two_q <= 1'b0;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
            busy_q <= 1'b0;
            addr_ack_q <= 1'b0;
            data_ack_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            unique case (st_q)
                MS_IDLE: if (req) begin
                    st_q <= MS_START;
                    busy_q <= 1'b1;
                    sh_q <= {req_addr, 1'b0};
                    nxt_q <= req_data;
                    two_q <= req_two;
                    byte1_q <= 1'b1;
                    ph_q <= 2'h0;
                    addr_ack_q <= 1'b0;
                    data_ack_q <= 1'b0;
                end
                MS_START: if (tick) begin
                    ph_q <= ph_q + 2'h1;
                    if (ph_q == 2'h1) sda_oe_q <= 1'b1;
                    if (ph_q == 2'h3) begin
                        scl_oe_q <= 1'b1;
                        st_q <= MS_BIT;
                        bit_q <= 4'h0;
                    end
                end
                MS_BIT, MS_ACK: if (tick) begin
                    ph_q <= ph_q + 2'h1;
                    if (ph_q == 2'h0) begin
                        sda_oe_q <= st_q == MS_BIT ? ~sh_q[7] : 1'b0;
                        scl_oe_q <= 1'b1;
                    end
                    if (ph_q == 2'h1) scl_oe_q <= 1'b0;
                    if (ph_q == 2'h2 && st_q == MS_ACK) begin
                        if (byte1_q) addr_ack_q <= ~sda_s_q[1];
                        else data_ack_q <= ~sda_s_q[1];
                    end
                    if (ph_q == 2'h3) begin
                        scl_oe_q <= 1'b1;
                        if (st_q == MS_BIT) begin
                            sh_q <= {sh_q[6:0], 1'b0};
                            bit_q <= bit_q + 4'h1;
                            if (bit_q == BIT_LAST) st_q <= MS_ACK;
                        end else if (byte1_q && two_q) begin
                            byte1_q <= 1'b0;
                            sh_q <= nxt_q;
                            bit_q <= 4'h0;
                            st_q <= MS_BIT;
                        end else begin
                            st_q <= MS_STOP;
                        end
                    end
                end
                MS_STOP: if (tick) begin
                    ph_q <= ph_q + 2'h1;
                    if (ph_q == 2'h0) sda_oe_q <= 1'b1;
                    if (ph_q == 2'h1) scl_oe_q <= 1'b0;
                    if (ph_q == 2'h3) begin
                        sda_oe_q <= 1'b0;
                        st_q <= MS_DONE;
                    end
                end
                MS_DONE: begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                    st_q <= MS_IDLE;
                end
                default: st_q <= MS_IDLE;
            endcase
        end
    end
    assign bus.clk_out = 1'b0;
    assign bus.clk_oe = scl_oe_q;
    assign bus.data_out = 1'b0;
    assign bus.data_oe = sda_oe_q;
endmodule : gsp_master

// ===== gsp_chk_sva.sv
`timescale 1ns/10ps
module gsp_chk (
    input wire logic clk,
    input wire logic nrst,
    input wire logic clk_out,
    input wire logic clk_oe,
    input wire logic data_out,
    input wire logic data_oe,
    input wire logic dev_data_out,
    input wire logic dev_data_oe,
    input wire clk_line,
    input wire data_line
);
    logic [4:0] nb_q;
    logic scl_q;
    logic sda_q;
    logic [11:0] oe_n_q;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // clock rises since start; the stop's own release rise counts too
    always_ff @(posedge clk) begin
        scl_q <= clk_line;
        sda_q <= data_line;
        if (!nrst || (scl_q && clk_line && sda_q && !data_line)) begin
            nb_q <= 5'h00;
        end else if (!scl_q && clk_line) begin
            nb_q <= nb_q + 5'h01;
        end
    end
    // cycles the device has held its ack, saturating
    always_ff @(posedge clk) begin
        if (!nrst || !dev_data_oe) begin
            oe_n_q <= 12'h000;
        end else if (oe_n_q != 12'hFFF) begin
            oe_n_q <= oe_n_q + 12'h001;
        end
    end
    property p_dev_low; dev_data_oe |-> !dev_data_out; endproperty
    a_dev_low: assert property (p_dev_low) else $error("dev drives high");
    property p_mst_low; !(clk_oe && clk_out) && !(data_oe && data_out); endproperty
    a_mst_low: assert property (p_mst_low) else $error("mst drives high");
    property p_clk_rel; !clk_oe |-> clk_line; endproperty
    a_clk_rel: assert property (p_clk_rel) else $error("clock pulled by dev");
    property p_dev_hold; clk_line && $past(clk_line) |-> $stable(dev_data_oe); endproperty
    a_dev_hold: assert property (p_dev_hold) else $error("dev data moved");
    property p_ack_lo; $rose(dev_data_oe) |-> !clk_line ##[1:600] clk_line; endproperty
    a_ack_lo: assert property (p_ack_lo) else $error("ack timing");
    property p_ack_len; $fell(dev_data_oe) |-> oe_n_q >= 12'h197 && oe_n_q <= 12'h4B7;
    endproperty
    a_ack_len: assert property (p_ack_len) else $error("ack length");
    property p_start; clk_line && $past(clk_line) && $fell(data_line) |-> ##[1:600] !clk_line;
    endproperty
    a_start: assert property (p_start) else $error("start hangs");
    property p_frame; clk_line && $past(clk_line) && $rose(data_line) |-> nb_q == 5'h0A ||
        nb_q == 5'h13; endproperty
    a_frame: assert property (p_frame) else $error("bit count");
    property p_stop; clk_line && $past(clk_line) && $rose(data_line) |-> (!clk_oe && !data_oe) [*8];
    endproperty
    a_stop: assert property (p_stop) else $error("bus not idle");
endmodule : gsp_chk

// ===== gamma_ref_serial_slave_port_bench.sv
`timescale 1ns/10ps
module gamma_ref_serial_slave_port_bench;
    import gsp_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic ap = 1'b0;
    logic bp = 1'b0;
    logic req = 1'b0;
    logic [6:0] ra = 7'h00;
    logic [7:0] rdat = 8'h00;
    logic r2 = 1'b0;
    logic bk, hs, gc, wv, rd, busy, aa, da, done;
    logic [7:0] wb;
    int err_count = 0;
    int n_tests = 0;
    int cyc = 0;
    int gcn = 0;
    logic hsn = 1'b0;
    logic [7:0] got[$];
    logic [31:0] rng = 32'h0026EFB4;
    gsp_if gsp_if_inst ();
    gsp_slave gsp_slave_inst (.clk(clk), .nrst(nrst), .bus(gsp_if_inst), .address_select_pin(ap),
        .bank_select_pin(bp), .bank_sel_q(bk), .hs_mode_q(hs), .gc_reset_q(gc), .wr_valid_q(wv),
        .wr_byte_q(wb), .rd_dir_q(rd));
    gsp_master gsp_master_inst (.clk(clk), .nrst(nrst), .bus(gsp_if_inst), .req(req),
        .req_addr(ra), .req_data(rdat), .req_two(r2), .busy_q(busy), .addr_ack_q(aa),
        .data_ack_q(da), .done_q(done));
    gsp_chk gsp_chk_inst (.clk(clk), .nrst(nrst), .clk_out(gsp_if_inst.clk_out),
        .clk_oe(gsp_if_inst.clk_oe), .data_out(gsp_if_inst.data_out),
        .data_oe(gsp_if_inst.data_oe), .dev_data_out(gsp_if_inst.dev_data_out),
        .dev_data_oe(gsp_if_inst.dev_data_oe), .clk_line(gsp_if_inst.clk_line),
        .data_line(gsp_if_inst.data_line));
    initial begin
        forever #2.5 clk = ~clk;
    end
    task automatic report_and_stop();
        if (err_count == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop
    // six frames of up to 20 bits at 500 cycles a bit
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (wv === 1'b1) got.push_back(wb);
        if (gc === 1'b1) gcn <= gcn + 1;
        if (hs === 1'b1) hsn <= 1'b1;
        if (cyc == 80000) begin
            err_count++;
            report_and_stop();
        end
    end
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    task automatic xfer(input logic [6:0] a, input logic [7:0] d, input logic two, input logic p);
        logic m;
        logic g6;
        int n;
        rng = xs(rng);
        @(negedge clk);
        ap = p;
        bp = rng[0];
        ra = a;
        rdat = d;
        r2 = two;
        gcn = 0;
        hsn = 1'b0;
        got.delete();
        repeat (4) @(negedge clk);
        req = 1'b1;
        n = 0;
        while (busy !== 1'b1 && n < 10) begin
            @(negedge clk);
            n++;
        end
        req = 1'b0;
        while (done !== 1'b1) @(negedge clk);
        repeat (20) @(negedge clk);
        m = (a[6:1] == ADDR_HI) && (a[0] == p);
        g6 = (a == 7'h00) && two && (d == GC_RESET);
        chk("addr_ack", {7'h00, m || a == 7'h00}, {7'h00, aa});
        if (two) chk("data_ack", {7'h00, m || g6}, {7'h00, da});
        chk("gc_reset", {7'h00, g6}, gcn[7:0]);
        chk("wr_count", {7'h00, m && two}, 8'(got.size()));
        if (got.size() > 0) chk("wr_byte", d, got[0]);
        chk("hs_seen", {7'h00, a[6:2] == HS_CODE_HI}, {7'h00, hsn});
        chk("hs_stop", 8'h00, {7'h00, hs});
        chk("rd_dir", 8'h00, {7'h00, rd});
        chk("bank", {7'h00, rng[0]}, {7'h00, bk});
    endtask : xfer
    initial begin
        repeat (5) @(negedge clk);
        nrst = 1'b1;
        rng = xs(rng);
        xfer(7'h75, rng[7:0], 1'b1, 1'b0);
        xfer(7'h74, rng[15:8], 1'b0, 1'b0);
        xfer(7'h75, rng[23:16], 1'b1, 1'b1);
        xfer(GC_ADDR[7:1], GC_RESET, 1'b1, 1'b0);
        xfer(7'h00, {rng[7:4] | 4'h1, rng[3:0]}, 1'b1, 1'b1);
        xfer({HS_CODE_HI, rng[9:8]}, 8'h00, 1'b0, 1'b0);
        report_and_stop();
    end
endmodule : gamma_ref_serial_slave_port_bench
